// ### rtl/acr_pkg.sv
// Purpose: Shared constants and types for the channel 6/7 trim registers
// Assumes: AHB-Lite slave, 32-bit data, registers are 16 bits wide
// Notes: Printed offsets are word indices; byte address is index times four
package acr_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ACR_IDX_CH6_GAIN_HIGH = 8'h2a;
    localparam logic [7:0] ACR_IDX_CH6_GAIN_LOW = 8'h2b;
    localparam logic [7:0] ACR_IDX_CH7_CONFIG = 8'h2c;
    localparam logic [7:0] ACR_IDX_CH7_OFFSET_HIGH = 8'h2d;
    localparam logic [7:0] ACR_IDX_CH7_OFFSET_LOW = 8'h2e;
    localparam logic [7:0] ACR_IDX_CH7_GAIN_HIGH = 8'h2f;
    localparam logic [7:0] ACR_IDX_CH7_GAIN_LOW = 8'h30;
    localparam int ACR_ADDR_WIDTH = 10;
    localparam int ACR_IDX_LSB = 2;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [15:0] ACR_RST_GAIN_HIGH = 16'h8000;
    localparam logic [15:0] ACR_RST_ZERO = 16'h0000;
    localparam logic [7:0] ACR_RST_BYTE = 8'h00;
    localparam logic [9:0] ACR_RST_DELAY = 10'h000;
    localparam logic [1:0] ACR_RST_SELECT = 2'h0;
    localparam logic ACR_RST_BYPASS = 1'h0;
    localparam logic ACR_READY = 1'h1;
    localparam logic ACR_RESP_OKAY = 1'h0;
    localparam logic [2:0] ACR_CFG_RSVD = 3'h0;
    localparam logic [7:0] ACR_LOW_RSVD = 8'h00;
    localparam logic [15:0] ACR_PAD16 = 16'h0000;
    localparam int ACR_DELAY_MSB = 15;
    localparam int ACR_DELAY_LSB = 6;
    localparam int ACR_BYPASS_BIT = 2;
    localparam int ACR_SELECT_MSB = 1;
    localparam int ACR_SELECT_LSB = 0;
    localparam int ACR_LOW_MSB = 15;
    localparam int ACR_LOW_LSB = 8;

    // Input selection codes
    localparam logic [1:0] ACR_SEL_PINS = 2'h0;
    localparam logic [1:0] ACR_SEL_SHORT = 2'h1;
    localparam logic [1:0] ACR_SEL_TEST_POS = 2'h2;
    localparam logic [1:0] ACR_SEL_TEST_NEG = 2'h3;

    // AHB encodings
    localparam logic [1:0] ACR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] ACR_HTRANS_SEQ = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [9:0] ch7_sample_delay;
        logic ch7_dc_reject_bypass;
        logic [1:0] ch7_input_select;
    } acr_cfg_type;

    typedef struct packed {
        logic [23:0] ch6_gain;
        logic [23:0] ch7_offset;
        logic [23:0] ch7_gain;
    } acr_trim_type;

    typedef struct packed {
        logic [15:0] ch6_gain_word_high;
        logic [7:0] ch6_gain_word_low;
        acr_cfg_type cfg;
        logic [15:0] ch7_offset_word_high;
        logic [7:0] ch7_offset_word_low;
        logic [15:0] ch7_gain_word_high;
        logic [7:0] ch7_gain_word_low;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        acr_trim_type trim;
        acr_cfg_type cfg_out;
        logic bus_ready;
        logic bus_err;
    } acr_state_type;

endpackage : acr_pkg

// ### rtl/acr_regs.sv
// Purpose: Channel 6 gain trim and channel 7 configuration/trim registers
// Assumes: AHB-Lite single word transfers; zero wait state slave
// Notes: Calibration words and channel 7 settings leave as registered outputs
// ----------------------------------------------------------------------
// Summary of operation
// - Channel 7 config bits 15:6 hold a signed 10-bit sample delay.
// - Config bit 2 set bypasses DC rejection for channel 7, clear follows global.
// - Config bits 1:0 pick pins, shorted inputs, or positive/negative test.
// - Config bits 5:3 are read-only zero.
// - Offset high holds bits 23:8 of the signed channel 7 offset trim.
// - Offset low bits 15:8 hold offset trim bits 7:0.
// - Gain high holds bits 23:8 of the unsigned channel 7 gain trim.
// - Gain low bits 15:8 hold channel 7 gain trim bits 7:0.
// - Channel 6 gain high holds bits 23:8 of its unsigned gain trim.
// - Channel 6 gain low bits 15:8 hold its gain trim bits 7:0.
// - Bits 7:0 of every low trim register read as zero.
// - Channel 7 gain high resets to unity 8000h and sits at index 2Fh.
// - Channel 7 config, offset and gain low reset to zero; config at 2Ch.
// - Channel 7 gain low is at 30h, offset high/low at 2Dh and 2Eh.
// - Channel 6 gain high sits at 2Ah and resets to 8000h.
//
// Register access over AHB-Lite was left to the implementer.
module acr_regs
    import acr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ACR_ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Channel settings and trim words
    output acr_cfg_type ch7_config,
    output acr_trim_type trim_words
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    acr_state_type st_ff;
    acr_state_type nxt_st;

    // Address phase qualifiers
    logic access;
    logic [7:0] rd_idx;
    // Data phase write strobes, one per register
    logic wr_ch6_gain_high;
    logic wr_ch6_gain_low;
    logic wr_ch7_config;
    logic wr_ch7_offset_high;
    logic wr_ch7_offset_low;
    logic wr_ch7_gain_high;
    logic wr_ch7_gain_low;
    // Read mux result and write data lane
    logic [15:0] rd_val;
    logic [15:0] wd;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        wr_ch6_gain_high = 1'h0;
        wr_ch6_gain_low = 1'h0;
        wr_ch7_config = 1'h0;
        wr_ch7_offset_high = 1'h0;
        wr_ch7_offset_low = 1'h0;
        wr_ch7_gain_high = 1'h0;
        wr_ch7_gain_low = 1'h0;
        // Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored
        access = hsel && hready &&
                 (htrans == ACR_HTRANS_NONSEQ || htrans == ACR_HTRANS_SEQ);
        rd_idx = haddr[ACR_ADDR_WIDTH-1:ACR_IDX_LSB];
        wd = hwdata[15:0];

        // --------------------------------------------------------------
        // Write strobes
        // --------------------------------------------------------------
        // The index was captured in the address phase; the data only
        // stands now, one cycle later, so the decode uses the held index
        if (st_ff.wr_pend) begin
            case (st_ff.wr_idx)
                ACR_IDX_CH6_GAIN_HIGH: begin
                    wr_ch6_gain_high = 1'h1;
                end
                ACR_IDX_CH6_GAIN_LOW: begin
                    wr_ch6_gain_low = 1'h1;
                end
                ACR_IDX_CH7_CONFIG: begin
                    wr_ch7_config = 1'h1;
                end
                ACR_IDX_CH7_OFFSET_HIGH: begin
                    wr_ch7_offset_high = 1'h1;
                end
                ACR_IDX_CH7_OFFSET_LOW: begin
                    wr_ch7_offset_low = 1'h1;
                end
                ACR_IDX_CH7_GAIN_HIGH: begin
                    wr_ch7_gain_high = 1'h1;
                end
                ACR_IDX_CH7_GAIN_LOW: begin
                    wr_ch7_gain_low = 1'h1;
                end
                default: begin
                    // Unmapped writes are dropped; the response stays OKAY
                end
            endcase
        end

        // --------------------------------------------------------------
        // Register updates
        // --------------------------------------------------------------
        // Low registers keep only their upper byte; the reserved byte has
        // no storage, so a write there cannot leave a stale bit behind
        if (wr_ch6_gain_high) begin
            nxt_st.ch6_gain_word_high = wd;
        end
        if (wr_ch6_gain_low) begin
            nxt_st.ch6_gain_word_low =
                wd[ACR_LOW_MSB:ACR_LOW_LSB];
        end
        if (wr_ch7_config) begin
            // Bits 5:3 of the write data are never looked at
            nxt_st.cfg.ch7_sample_delay =
                wd[ACR_DELAY_MSB:ACR_DELAY_LSB];
            nxt_st.cfg.ch7_dc_reject_bypass = wd[ACR_BYPASS_BIT];
            nxt_st.cfg.ch7_input_select =
                wd[ACR_SELECT_MSB:ACR_SELECT_LSB];
        end
        if (wr_ch7_offset_high) begin
            nxt_st.ch7_offset_word_high = wd;
        end
        if (wr_ch7_offset_low) begin
            nxt_st.ch7_offset_word_low =
                wd[ACR_LOW_MSB:ACR_LOW_LSB];
        end
        if (wr_ch7_gain_high) begin
            nxt_st.ch7_gain_word_high = wd;
        end
        if (wr_ch7_gain_low) begin
            nxt_st.ch7_gain_word_low =
                wd[ACR_LOW_MSB:ACR_LOW_LSB];
        end

        // A write is remembered for exactly one cycle, its data phase
        nxt_st.wr_pend = access && hwrite;
        nxt_st.wr_idx = rd_idx;

        // --------------------------------------------------------------
        // Read decode
        // --------------------------------------------------------------
        // Reserved bits are fixed zero, not storage
        case (rd_idx)
            ACR_IDX_CH6_GAIN_HIGH: begin
                rd_val = st_ff.ch6_gain_word_high;
            end
            ACR_IDX_CH6_GAIN_LOW: begin
                rd_val = {st_ff.ch6_gain_word_low, ACR_LOW_RSVD};
            end
            ACR_IDX_CH7_CONFIG: begin
                rd_val = {st_ff.cfg.ch7_sample_delay, ACR_CFG_RSVD,
                          st_ff.cfg.ch7_dc_reject_bypass,
                          st_ff.cfg.ch7_input_select};
            end
            ACR_IDX_CH7_OFFSET_HIGH: begin
                rd_val = st_ff.ch7_offset_word_high;
            end
            ACR_IDX_CH7_OFFSET_LOW: begin
                rd_val = {st_ff.ch7_offset_word_low, ACR_LOW_RSVD};
            end
            ACR_IDX_CH7_GAIN_HIGH: begin
                rd_val = st_ff.ch7_gain_word_high;
            end
            ACR_IDX_CH7_GAIN_LOW: begin
                rd_val = {st_ff.ch7_gain_word_low, ACR_LOW_RSVD};
            end
            default: begin
                rd_val = ACR_RST_ZERO;
            end
        endcase
        if (access && !hwrite) begin
            nxt_st.rdata = {ACR_PAD16, rd_val};
        end

        // Joined words are built from the next register values, so the
        // outputs stay flopped yet change on the same edge as the register
        nxt_st.trim.ch6_gain = {nxt_st.ch6_gain_word_high,
                                nxt_st.ch6_gain_word_low};
        nxt_st.trim.ch7_offset = {nxt_st.ch7_offset_word_high,
                                  nxt_st.ch7_offset_word_low};
        nxt_st.trim.ch7_gain = {nxt_st.ch7_gain_word_high,
                                nxt_st.ch7_gain_word_low};
        nxt_st.cfg_out = nxt_st.cfg;

        // Zero wait states: every transfer completes in its first data
        // phase cycle and always with an OKAY response
        nxt_st.bus_ready = ACR_READY;
        nxt_st.bus_err = ACR_RESP_OKAY;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff.ch6_gain_word_high <= ACR_RST_GAIN_HIGH;
            st_ff.ch6_gain_word_low <= ACR_RST_BYTE;
            st_ff.cfg.ch7_sample_delay <= ACR_RST_DELAY;
            st_ff.cfg.ch7_dc_reject_bypass <= ACR_RST_BYPASS;
            st_ff.cfg.ch7_input_select <= ACR_RST_SELECT;
            st_ff.ch7_offset_word_high <= ACR_RST_ZERO;
            st_ff.ch7_offset_word_low <= ACR_RST_BYTE;
            st_ff.ch7_gain_word_high <= ACR_RST_GAIN_HIGH;
            st_ff.ch7_gain_word_low <= ACR_RST_BYTE;
            st_ff.wr_pend <= 1'b0;
            st_ff.wr_idx <= ACR_RST_BYTE;
            st_ff.rdata <= {ACR_PAD16, ACR_RST_ZERO};
            st_ff.trim.ch6_gain <= {ACR_RST_GAIN_HIGH, ACR_RST_BYTE};
            st_ff.trim.ch7_offset <= {ACR_RST_ZERO, ACR_RST_BYTE};
            st_ff.trim.ch7_gain <= {ACR_RST_GAIN_HIGH, ACR_RST_BYTE};
            st_ff.cfg_out.ch7_sample_delay <= ACR_RST_DELAY;
            st_ff.cfg_out.ch7_dc_reject_bypass <= ACR_RST_BYPASS;
            st_ff.cfg_out.ch7_input_select <= ACR_RST_SELECT;
            // The slave reads as ready even while held in reset
            st_ff.bus_ready <= ACR_READY;
            st_ff.bus_err <= ACR_RESP_OKAY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a field of the state register, so none of them
    // carries a combinational path from the bus inputs
    assign hrdata = st_ff.rdata;
    assign hreadyout = st_ff.bus_ready;
    assign hresp = st_ff.bus_err;
    assign ch7_config = st_ff.cfg_out;
    assign trim_words = st_ff.trim;

endmodule : acr_regs

// ### sim/acr_regs_properties.sv
// Purpose: Bus and output properties of the trim register block
// Assumes: One AHB-Lite master, single word transfers
// Notes: Bound to acr_regs; sees its ports only
module acr_regs_chk
    import acr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [ACR_ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Settings and trim words
    input wire acr_cfg_type ch7_config,
    input wire acr_trim_type trim_words
);
    // -------------------------------------------------------------
    // Transfer decode
    // -------------------------------------------------------------
    wire take = hsel && hready && htrans[1];
    wire wr = take && hwrite;
    wire rd = take && !hwrite;
    wire low_rd = rd && (haddr == 10'h0ac || haddr == 10'h0b8
        || haddr == 10'h0c0);
    wire [7:0] idx = haddr[9:2];
    wire hit = idx >= 8'h2a && idx <= 8'h30;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Data lands one cycle after the address phase is taken
    a_cfg_fields: assert property (wr && haddr == 10'h0b0 |=> ##1
        ch7_config == {$past(hwdata[15:6]), $past(hwdata[2]),
        $past(hwdata[1:0])}) else $error("config fields wrong");
    a_cfg_rsvd: assert property (rd && haddr == 10'h0b0 |=>
        hrdata[5:3] == 3'h0) else $error("config reserved not zero");
    a_offset_high: assert property (wr && haddr == 10'h0b4 |=> ##1
        trim_words.ch7_offset[23:8] == $past(hwdata[15:0]))
        else $error("offset high wrong");
    a_offset_low: assert property (wr && haddr == 10'h0b8 |=> ##1
        trim_words.ch7_offset[7:0] == $past(hwdata[15:8]))
        else $error("offset low wrong");
    a_gain7_high: assert property (wr && haddr == 10'h0bc |=> ##1
        trim_words.ch7_gain[23:8] == $past(hwdata[15:0]))
        else $error("ch7 gain high wrong");
    a_gain7_low: assert property (wr && haddr == 10'h0c0 |=> ##1
        trim_words.ch7_gain[7:0] == $past(hwdata[15:8]))
        else $error("ch7 gain low wrong");
    a_gain6_high: assert property (wr && haddr == 10'h0a8 |=> ##1
        trim_words.ch6_gain[23:8] == $past(hwdata[15:0]))
        else $error("ch6 gain high wrong");
    a_gain6_low: assert property (wr && haddr == 10'h0ac |=> ##1
        trim_words.ch6_gain[7:0] == $past(hwdata[15:8]))
        else $error("ch6 gain low wrong");
    a_low_rsvd: assert property (low_rd |=> hrdata[7:0] == 8'h00)
        else $error("low reserved byte not zero");
    // Checked from the second reset edge: the first may still meet unknowns
    a_reset_vals: assert property (disable iff (1'b0)
        !hresetn ##1 !hresetn |-> trim_words == {24'h800000, 24'h000000,
        24'h800000} && ch7_config == 13'h0000 && hreadyout && !hresp)
        else $error("reset values wrong");
    a_trim_hold: assert property (!(wr && hit) |=> ##1
        $stable(trim_words) && $stable(ch7_config))
        else $error("outputs changed without a mapped write");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    c_cfg_wr: cover property (wr && haddr == 10'h0b0);
    c_low_rd: cover property (low_rd);
    c_unmapped: cover property (rd && haddr == 10'h0c4);
    c_unmapped_wr: cover property (wr && !hit);
endmodule : acr_regs_chk

bind acr_regs acr_regs_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ch7_config(ch7_config),
    .trim_words(trim_words));

// ### sim/acr_regs_tb_top.sv
// Purpose: Self-checking bench for the channel 6/7 trim registers
// Assumes: Zero wait state slave, hready tied back from hreadyout
// Notes: Byte address is four times the register index
module acr_regs_tb_top;
    import acr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk, hresetn, hsel, hwrite;
    logic [9:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic hreadyout, hresp;
    acr_cfg_type ch7_config;
    acr_trim_type trim_words;
    wire hready = hreadyout;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [9:0] ad [7] = '{10'h0a8, 10'h0ac, 10'h0b0, 10'h0b4, 10'h0b8,
        10'h0bc, 10'h0c0};
    logic [15:0] rv [7] = '{16'h8000, 16'h0, 16'h0, 16'h0, 16'h0,
        16'h8000, 16'h0};
    logic [15:0] mk [7] = '{16'hffff, 16'hff00, 16'hffc7, 16'hffff,
        16'hff00, 16'hffff, 16'hff00};
    acr_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ch7_config(ch7_config),
        .trim_words(trim_words));
    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [9:0] a,
        input logic [15:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= ACR_HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {16'h0000, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : xfer
    task automatic rd_chk(input logic [9:0] a, input logic [15:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 16'h0000, q);
        check(q, {16'h0000, e});
        check({hreadyout, hresp}, 2'b10);
    endtask : rd_chk
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 7; i++) rd_chk(ad[i], rv[i]);
        check(trim_words, {24'h800000, 24'h0, 24'h800000});
        check(ch7_config, 13'h0000);
    endtask : t_reset
    task automatic t_rw();
        logic [31:0] q;
        for (int i = 0; i < 7; i++) xfer(1'b1, ad[i], 16'hffff, q);
        for (int i = 0; i < 7; i++) rd_chk(ad[i], mk[i]);
        check(trim_words, {72{1'b1}});
        check(ch7_config, 13'h1fff);
        // Distinct high and low bytes expose a swapped join
        for (int i = 0; i < 7; i++) xfer(1'b1, ad[i], i == 2 ? 16'h8f3e :
            (mk[i] == 16'hff00 ? 16'h5aff : 16'hc3a5), q);
        rd_chk(10'h0b0, 16'h8f06);
        check(trim_words, {3{24'hc3a55a}});
        check(ch7_config, {10'h23c, 1'b1, 2'h2});
        xfer(1'b1, 10'h0c4, 16'hffff, q);
        check(trim_words, {3{24'hc3a55a}});
        check(ch7_config, {10'h23c, 1'b1, 2'h2});
        rd_chk(10'h0c4, 16'h0000);
        rd_chk(10'h0a4, 16'h0000);
    endtask : t_rw
    task automatic t_select();
        logic [31:0] q;
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, 10'h0b0, 16'h0000 | c[1:0], q);
            @(negedge hclk);
            check(ch7_config.ch7_input_select, c[1:0]);
            check(ch7_config.ch7_dc_reject_bypass, 1'b0);
        end
    endtask : t_select
    // Reset in mid-run, with every register away from its reset value
    task automatic t_mid_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        check(trim_words, {24'h800000, 24'h0, 24'h800000});
        check(ch7_config, 13'h0000);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
    endtask : t_mid_reset
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 10'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_rw();
        t_select();
        t_mid_reset();
        end_of_test();
    end
endmodule : acr_regs_tb_top
